// File: logic/gpib_bus_sync.v
// Two-flop synchroniser for asynchronous bus lines, idle level high
`timescale 1ns/1ps
module gpib_bus_sync #(
	parameter WIDTH = 2
) (
	input  wire             sys_clk_in,
	input  wire             rst_n_in,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] stage1_r;
	reg [WIDTH-1:0] stage2_r;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge sys_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					stage1_r[i] <= 1'b1;
					stage2_r[i] <= 1'b1;
				end else begin
					stage1_r[i] <= async_in[i];
					stage2_r[i] <= stage1_r[i];
				end
			end
		end
	endgenerate

	assign sync_out = stage2_r;
endmodule // gpib_bus_sync

// File: logic/gpib_sgz_regs.vh
// Register map, field positions and reset values of the status group zero block
`ifndef GPIB_SGZ_REGS_VH
`define GPIB_SGZ_REGS_VH

// Byte offsets on the APB
`define SGZ_OFS_STATUS      8'h00
`define SGZ_OFS_MASK        8'h04
`define SGZ_OFS_SERIAL_POLL_RESPONSE_REG        8'h08
`define SGZ_OFS_AUX         8'h0C
`define SGZ_OFS_CONFIG      8'h10

// Status and mask bit positions
`define SGZ_BIT_GLOBAL_IRQ_ENABLE       7
`define SGZ_BIT_STATUS_BYTE_OUT_FLAG        6
`define SGZ_BIT_NL          5
`define SGZ_BIT_NEWLINE_TERMINATOR_ENABLE        5
`define SGZ_BIT_EOS         4
`define SGZ_BIT_INTERFACE_CLEAR_IRQ        3
`define SGZ_BIT_ATTENTION_IRQ        2
`define SGZ_BIT_SYNC        0

// Status bits that read back; bits 7, 1 and 0 and the uncovered bits read zero
`define SGZ_STATUS_RMASK    8'h7C
// Mask bits that software can write
`define SGZ_MASK_WMASK      8'hED
// Interrupt enables that gate status bits of equal position
`define SGZ_IRQ_BITS        8'h4C

// Auxiliary command bits
`define SGZ_AUX_CLR_INTERFACE_CLEAR_IRQ    0
`define SGZ_AUX_CLR_ATTENTION_IRQ    1
`define SGZ_AUX_REQT        2
`define SGZ_AUX_REQF        3

// Configuration fields
`define SGZ_CFG_STATIC_STATUS_BITS_MODE        0
`define SGZ_CFG_STRING_MATCH_ENABLE        1
`define SGZ_CFG_EOSC_LO     8
`define SGZ_CFG_EOSC_HI     15

// Reset values
`define SGZ_RST_STATUS      8'h00
`define SGZ_RST_MASK        8'h80
`define SGZ_RST_SERIAL_POLL_RESPONSE_REG        8'h00
`define SGZ_RST_EOS_CHAR    8'h0A

// Characters
`define SGZ_NL_CHAR         8'h0A
`define SGZ_NL_CHAR7        7'h0A

// Service request bit inside the serial poll response
`define SGZ_SERIAL_POLL_RESPONSE_REG_RSV        6

`endif

// File: logic/gpib_status_group_zero.v
// Status group zero: serial poll, newline, end-of-string, IFC and ATN flags with APB access
//
// Function
// - Enable low: service request from response register bit
// - Enable low: poll reply is response register
// - Enable high: request only via request-true command
// - Set status-byte-out flag when enabled and polled
// - Host writes reply byte; device sends it
// - Clear flag on reset, response write, poll end
// - Set newline flag on accepted newline byte
// - Clear newline flag on other accepted byte
// - Newline-end compares low seven bits only
// - Newline-end byte acts as end-or-identify
// - Set string flag on matching accepted byte
// - Clear string flag on mismatch or disable
// - Set interface-clear flag on line assertion
// - Clear it by reset, read, or command
// - Set attention flag on line assertion
// - Clear it by reset, read, or command
// - Enabled status conditions raise interrupt request
// - Defer status setting during a status read
// - Reset clears mask except global enable
// - Global enable low keeps interrupt pin idle
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "gpib_sgz_regs.vh"
module gpib_status_group_zero (
	input  wire        sys_clk_in,
	input  wire        rst_n_in,
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [7:0]  paddr_in,
	input  wire [31:0] pwdata_in,
	output wire [31:0] prdata_out,
	output wire        pready_out,
	output wire        pslverr_out,
	input  wire        ifc_n_in,
	input  wire        atn_n_in,
	input  wire        listener_active_state_in,
	input  wire        accept_data_state_in,
	input  wire        serial_poll_active_state_in,
	input  wire [7:0]  data_in,
	input  wire        eoi_in,
	output wire        irq_n_out,
	output wire        srq_out,
	output wire [7:0]  sp_reply_out,
	output wire        end_detect_out
);
	// Reset release
	reg rst_s1_r;
	reg rst_s2_r;
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	wire rst_n;
	assign rst_n = rst_s2_r;

	// Bus lines are asynchronous
	wire [1:0] line_sync;
	gpib_bus_sync #(
		.WIDTH(2)
	) u_line_sync (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n),
		.async_in   ({ifc_n_in, atn_n_in}),
		.sync_out   (line_sync)
	);
	wire ifc_n_s;
	wire atn_n_s;
	assign ifc_n_s = line_sync[1];
	assign atn_n_s = line_sync[0];

	reg  [7:0]  status_r;
	reg  [7:0]  status_nxt;
	reg  [7:0]  pend_r;
	reg  [7:0]  pend_nxt;
	reg  [7:0]  mask_r;
	reg  [7:0]  serial_poll_response_reg_r;
	reg         static_status_bits_mode_r;
	reg         string_match_enable_r;
	reg  [7:0]  eos_char_r;
	reg         rsv_req_r;
	reg         ifc_prev_r;
	reg         atn_prev_r;
	reg         accept_data_state_prev_r;
	reg         status_byte_out_flag_cond_prev_r;
	reg  [31:0] prdata_r;
	reg         pready_r;
	reg         pslverr_r;
	reg         irq_n_r;
	reg         srq_r;
	reg         end_r;

	// APB decode
	wire        setup_phase;
	wire        xfer_done;
	wire        wr_en;
	wire        mapped;
	wire        wr_mask;
	wire        wr_serial_poll_response_reg;
	wire        wr_aux;
	wire        wr_cfg;
	wire        rd_sel;
	wire        rd_done;
	wire        rd_clr;
	assign setup_phase = psel_in & ~penable_in;
	assign xfer_done   = psel_in & penable_in & pready_r;
	assign mapped      = (paddr_in == `SGZ_OFS_STATUS) | (paddr_in == `SGZ_OFS_MASK) |
	                     (paddr_in == `SGZ_OFS_SERIAL_POLL_RESPONSE_REG) | (paddr_in == `SGZ_OFS_AUX) |
	                     (paddr_in == `SGZ_OFS_CONFIG);
	assign wr_en       = xfer_done & pwrite_in;
	assign wr_mask     = wr_en & (paddr_in == `SGZ_OFS_MASK);
	assign wr_serial_poll_response_reg     = wr_en & (paddr_in == `SGZ_OFS_SERIAL_POLL_RESPONSE_REG);
	assign wr_aux      = wr_en & (paddr_in == `SGZ_OFS_AUX);
	assign wr_cfg      = wr_en & (paddr_in == `SGZ_OFS_CONFIG);
	assign rd_sel      = psel_in & ~pwrite_in & (paddr_in == `SGZ_OFS_STATUS);
	assign rd_done     = rd_sel & penable_in & pready_r;
	assign rd_clr      = rd_done & ~static_status_bits_mode_r;

	wire cmd_clr_interface_clear_irq;
	wire cmd_clr_attention_irq;
	wire cmd_reqt;
	wire cmd_reqf;
	assign cmd_clr_interface_clear_irq = wr_aux & pwdata_in[`SGZ_AUX_CLR_INTERFACE_CLEAR_IRQ];
	assign cmd_clr_attention_irq = wr_aux & pwdata_in[`SGZ_AUX_CLR_ATTENTION_IRQ];
	assign cmd_reqt     = wr_aux & pwdata_in[`SGZ_AUX_REQT];
	assign cmd_reqf     = wr_aux & pwdata_in[`SGZ_AUX_REQF];

	// Byte acceptance: first cycle of accept-data while listener active
	wire acc_evt;
	wire is_nl;
	wire nl7;
	wire newline_terminator_enable;
	wire eos_hit;
	assign acc_evt = listener_active_state_in & accept_data_state_in & ~accept_data_state_prev_r;
	assign is_nl   = (data_in == `SGZ_NL_CHAR);
	assign nl7     = (data_in[6:0] == `SGZ_NL_CHAR7);
	assign newline_terminator_enable    = mask_r[`SGZ_BIT_NEWLINE_TERMINATOR_ENABLE];
	assign eos_hit = (data_in == eos_char_r) | (newline_terminator_enable & nl7);

	wire status_byte_out_irq_enable;
	wire status_byte_out_flag_cond;
	assign status_byte_out_irq_enable   = mask_r[`SGZ_BIT_STATUS_BYTE_OUT_FLAG];
	assign status_byte_out_flag_cond = status_byte_out_irq_enable & serial_poll_active_state_in;

	// Set events and clear conditions per status bit
	wire [7:0] ev;
	wire [7:0] drop;
	wire [7:0] clr;
	assign ev[7]  = 1'b0;
	assign ev[`SGZ_BIT_STATUS_BYTE_OUT_FLAG] = status_byte_out_flag_cond & ~status_byte_out_flag_cond_prev_r;
	assign ev[`SGZ_BIT_NL]   = acc_evt & is_nl;
	assign ev[`SGZ_BIT_EOS]  = acc_evt & string_match_enable_r & eos_hit;
	assign ev[`SGZ_BIT_INTERFACE_CLEAR_IRQ] = ifc_prev_r & ~ifc_n_s;
	assign ev[`SGZ_BIT_ATTENTION_IRQ] = atn_prev_r & ~atn_n_s;
	assign ev[1:0] = 2'b00;

	assign drop[7] = 1'b0;
	assign drop[`SGZ_BIT_STATUS_BYTE_OUT_FLAG] = wr_serial_poll_response_reg | ~serial_poll_active_state_in;
	assign drop[`SGZ_BIT_NL]   = acc_evt & ~is_nl;
	assign drop[`SGZ_BIT_EOS]  = (acc_evt & ~eos_hit) | ~string_match_enable_r;
	assign drop[`SGZ_BIT_INTERFACE_CLEAR_IRQ] = cmd_clr_interface_clear_irq;
	assign drop[`SGZ_BIT_ATTENTION_IRQ] = cmd_clr_attention_irq;
	assign drop[1:0] = 2'b00;

	assign clr = drop | {4'h0, rd_clr, rd_clr, 2'b00};

	// Events during a status read wait in pend_r; a set beats a clear
	always @* begin
		status_nxt = status_r & ~clr;
		pend_nxt   = 8'h00;
		if (rd_sel) begin
			pend_nxt = (pend_r & ~drop) | ev;
		end else begin
			status_nxt = status_nxt | (pend_r & ~drop) | ev;
		end
	end

	// Read mux
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0000_0000;
		case (paddr_in)
			`SGZ_OFS_STATUS: begin
				rd_mux = {24'h00_0000, status_r & `SGZ_STATUS_RMASK};
			end
			`SGZ_OFS_SERIAL_POLL_RESPONSE_REG: begin
				rd_mux = {24'h00_0000, serial_poll_response_reg_r};
			end
			`SGZ_OFS_CONFIG: begin
				rd_mux = {16'h0000, eos_char_r, 6'h00, string_match_enable_r, static_status_bits_mode_r};
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// Bus slave: one wait-free access cycle, data latched at setup
	always @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup_phase;
			pslverr_r <= setup_phase & ~mapped;
			if (setup_phase) begin
				prdata_r <= pwrite_in ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	// Software registers
	always @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			mask_r     <= `SGZ_RST_MASK;
			serial_poll_response_reg_r     <= `SGZ_RST_SERIAL_POLL_RESPONSE_REG;
			static_status_bits_mode_r     <= 1'b0;
			string_match_enable_r     <= 1'b0;
			eos_char_r <= `SGZ_RST_EOS_CHAR;
			rsv_req_r  <= 1'b0;
		end else begin
			if (wr_mask) begin
				mask_r <= pwdata_in[7:0] & `SGZ_MASK_WMASK;
			end
			if (wr_serial_poll_response_reg) begin
				serial_poll_response_reg_r <= pwdata_in[7:0];
			end
			if (wr_cfg) begin
				static_status_bits_mode_r     <= pwdata_in[`SGZ_CFG_STATIC_STATUS_BITS_MODE];
				string_match_enable_r     <= pwdata_in[`SGZ_CFG_STRING_MATCH_ENABLE];
				eos_char_r <= pwdata_in[`SGZ_CFG_EOSC_HI:`SGZ_CFG_EOSC_LO];
			end
			if (cmd_reqt) begin
				rsv_req_r <= 1'b1;
			end else if (cmd_reqf) begin
				rsv_req_r <= 1'b0;
			end
		end
	end

	// Status, history and outputs
	wire irq_any;
	wire srq_nxt;
	assign irq_any = |(status_r & mask_r & `SGZ_IRQ_BITS);
	assign srq_nxt = status_byte_out_irq_enable ? rsv_req_r : serial_poll_response_reg_r[`SGZ_SERIAL_POLL_RESPONSE_REG_RSV];

	always @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			status_r         <= `SGZ_RST_STATUS;
			pend_r           <= 8'h00;
			ifc_prev_r       <= 1'b1;
			atn_prev_r       <= 1'b1;
			accept_data_state_prev_r      <= 1'b0;
			status_byte_out_flag_cond_prev_r <= 1'b0;
			irq_n_r          <= 1'b1;
			srq_r            <= 1'b0;
			end_r            <= 1'b0;
		end else begin
			status_r         <= status_nxt;
			pend_r           <= pend_nxt;
			ifc_prev_r       <= ifc_n_s;
			atn_prev_r       <= atn_n_s;
			accept_data_state_prev_r      <= accept_data_state_in;
			status_byte_out_flag_cond_prev_r <= status_byte_out_flag_cond;
			irq_n_r          <= ~(mask_r[`SGZ_BIT_GLOBAL_IRQ_ENABLE] & irq_any);
			srq_r            <= srq_nxt;
			end_r            <= acc_evt & (eoi_in | (newline_terminator_enable & nl7));
		end
	end

	assign prdata_out     = prdata_r;
	assign pready_out     = pready_r;
	assign pslverr_out    = pslverr_r;
	assign irq_n_out      = irq_n_r;
	assign srq_out        = srq_r;
	assign sp_reply_out   = serial_poll_response_reg_r;
	assign end_detect_out = end_r;
endmodule // gpib_status_group_zero

// File: verif/gpib_bus_model.sv
// Far-side bus model: controller lines and accepted bytes
`timescale 1ns/1ps
module gpib_bus_model (
	input  wire       sys_clk_in,
	output reg        ifc_n_out = 1'b1,
	output reg        atn_n_out = 1'b1,
	output reg        listener_active_state_out = 1'b1,
	output reg        accept_data_state_out = 1'b0,
	output reg        serial_poll_active_state_out = 1'b0,
	output reg        eoi_out = 1'b0,
	output reg  [7:0] data_out = 8'hFF
);
task pulse(input f);
	@(posedge sys_clk_in);
	if (f)
		ifc_n_out <= 1'b0;
	else
		atn_n_out <= 1'b0;
	repeat (5) @(posedge sys_clk_in);
	ifc_n_out <= 1'b1;
	atn_n_out <= 1'b1;
endtask
// Byte valid only in the acceptance cycle, then inverted
task send(input [7:0] d, input e);
	@(posedge sys_clk_in);
	data_out <= d;
	eoi_out <= e;
	accept_data_state_out <= 1'b1;
	@(posedge sys_clk_in);
	accept_data_state_out <= 1'b0;
	eoi_out <= 1'b0;
	data_out <= ~d;
	repeat (2) @(posedge sys_clk_in);
endtask
task listen(input l);
	@(posedge sys_clk_in);
	listener_active_state_out <= l;
endtask
task poll(input s);
	@(posedge sys_clk_in);
	serial_poll_active_state_out <= s;
	repeat (3) @(posedge sys_clk_in);
endtask
endmodule // gpib_bus_model

// File: verif/gpib_sgz_sva.sv
// Port checker for status group zero
`timescale 1ns/1ps
module gpib_sgz_chk (
	input wire        sys_clk_in,
	input wire        rst_n_in,
	input wire        psel_in,
	input wire        penable_in,
	input wire        pwrite_in,
	input wire [7:0]  paddr_in,
	input wire [31:0] pwdata_in,
	input wire [31:0] prdata_out,
	input wire        pready_out,
	input wire        pslverr_out,
	input wire        ifc_n_in,
	input wire        atn_n_in,
	input wire        listener_active_state_in,
	input wire        accept_data_state_in,
	input wire        serial_poll_active_state_in,
	input wire [7:0]  data_in,
	input wire        eoi_in,
	input wire        irq_n_out,
	input wire        srq_out,
	input wire [7:0]  sp_reply_out,
	input wire        end_detect_out
);
default clocking @(posedge sys_clk_in); endclocking
default disable iff (!rst_n_in);
wire      acc_w = psel_in & penable_in & pready_out;
reg [4:0] en_r;
// Copy of global, poll, newline-end, IFC and ATN enables
always @(posedge sys_clk_in or negedge rst_n_in) begin
	if (!rst_n_in)
		en_r <= 5'h10;
	else if (acc_w && pwrite_in && paddr_in == 8'h04)
		en_r <= {pwdata_in[7:5], pwdata_in[3:2]};
end
chk_global_irq_enable_off: assert property (!en_r[4] && !$past(en_r[4]) |-> irq_n_out)
	else $error("irq with global enable off");
chk_rsv_srq: assert property (!en_r[3] && !$past(en_r[3]) && $stable(sp_reply_out)
	|-> srq_out == sp_reply_out[6]) else $error("srq differs from rsv");
chk_reply_wr: assert property (acc_w && pwrite_in && paddr_in == 8'h08
	|=> {24'h0, sp_reply_out} == ($past(pwdata_in) & 32'hFF)) else $error("reply not written");
chk_end_cause: assert property ($rose(accept_data_state_in) && listener_active_state_in
	&& (eoi_in || en_r[2] && data_in[6:0] == 7'h0A) |=> end_detect_out)
	else $error("end not flagged");
chk_end_pulse: assert property (end_detect_out |=> !end_detect_out)
	else $error("end longer than a cycle");
chk_undef_bit: assert property (acc_w && !pwrite_in && paddr_in == 8'h00
	|-> (prdata_out & ~32'h7C) == 32'h0) else $error("status spare bits set");
chk_ifc_irq: assert property ($fell(ifc_n_in) && en_r[4] && en_r[1]
	|-> ##[2:8] !irq_n_out) else $error("no irq on IFC");
chk_atn_irq: assert property ($fell(atn_n_in) && en_r[4] && en_r[0]
	|-> ##[2:8] !irq_n_out) else $error("no irq on ATN");
chk_poll_irq: assert property ($rose(serial_poll_active_state_in) && en_r[4] && en_r[3]
	|-> ##[1:4] !irq_n_out) else $error("no irq on poll");
cov_irq: cover property (!irq_n_out);
cov_end: cover property (end_detect_out);
cov_srq: cover property (srq_out);
endmodule // gpib_sgz_chk
bind gpib_status_group_zero gpib_sgz_chk u_chk (.*);

// File: verif/gpib_status_group_zero_bench.sv
// Self-checking bench for status group zero
`timescale 1ns/1ps
module gpib_status_group_zero_bench;
reg         clk = 1'b0;
reg         rst_n = 1'b0;
reg         psel = 1'b0;
reg         pen = 1'b0;
reg         pwr = 1'b0;
reg  [7:0]  pa = 8'h00;
reg  [31:0] pwd = 32'h0;
reg  [31:0] rd;
reg  [31:0] ends = 32'h0;
wire [31:0] prd;
wire        pslv;
reg         se;
wire        prdy, ifc_n, atn_n, listener_active_state, accept_data_state, serial_poll_active_state, eoi, irq_n, srq, endd;
wire [7:0]  dat, spr;
integer     err_count = 0;
integer     n_checks = 0;
integer     cyc = 0;
gpib_status_group_zero u_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
	.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
	.pready_out(prdy), .pslverr_out(pslv), .ifc_n_in(ifc_n), .atn_n_in(atn_n),
	.listener_active_state_in(listener_active_state), .accept_data_state_in(accept_data_state),
	.serial_poll_active_state_in(serial_poll_active_state), .data_in(dat), .eoi_in(eoi), .irq_n_out(irq_n),
	.srq_out(srq), .sp_reply_out(spr), .end_detect_out(endd));
gpib_bus_model u_bus (.sys_clk_in(clk), .ifc_n_out(ifc_n), .atn_n_out(atn_n),
	.listener_active_state_out(listener_active_state), .accept_data_state_out(accept_data_state), .serial_poll_active_state_out(serial_poll_active_state), .eoi_out(eoi), .data_out(dat));
always #10 clk = ~clk;
always @(posedge clk) begin
	cyc = cyc + 1;
	if (endd === 1'b1)
		ends = ends + 1;
	if (cyc == 5000) begin
		err_count = err_count + 1;
		end_of_test;
	end
end
task end_of_test;
	$display("mismatches %0d checks %0d", err_count, n_checks);
	if (err_count == 0 && n_checks > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
task chk(input string nm, input [31:0] s, input [31:0] e);
	n_checks = n_checks + 1;
	if (s !== e) begin
		err_count = err_count + 1;
		$display("[FAIL] %s expected %h seen %h", nm, e, s);
	end
endtask
task apb(input w, input [7:0] a, input [31:0] d);
	@(posedge clk);
	psel <= 1'b1;
	pwr <= w;
	pa <= a;
	pwd <= d;
	@(posedge clk);
	pen <= 1'b1;
	@(posedge clk);
	while (prdy !== 1'b1)
		@(posedge clk);
	rd = prd;
	se = pslv;
	psel <= 1'b0;
	pen <= 1'b0;
	#1;
endtask
task w(input integer n);
	repeat (n) @(posedge clk);
	#1;
endtask
task t_poll;
	apb(1, 8'h14, 32'hFF);
	chk("slverr", se, 1);
	apb(1, 8'h08, 32'h40);
	chk("slverr", se, 0);
	w(3);
	chk("srq", srq, 1);
	chk("reply", spr, 8'h40);
	apb(1, 8'h04, 32'hC0);
	w(3);
	chk("srq", srq, 0);
	apb(1, 8'h0C, 32'h04);
	w(3);
	chk("srq", srq, 1);
	apb(1, 8'h0C, 32'h08);
	w(3);
	chk("srq", srq, 0);
	u_bus.poll(1);
	apb(0, 8'h00, 0);
	chk("status_byte_out_flag", rd[6], 1);
	chk("irq", irq_n, 0);
	apb(1, 8'h08, 32'h55);
	apb(0, 8'h00, 0);
	chk("status_byte_out_flag", rd[6], 0);
	chk("reply", spr, 8'h55);
	u_bus.poll(0);
	u_bus.poll(1);
	u_bus.poll(0);
	apb(0, 8'h00, 0);
	chk("status_byte_out_flag", rd[6], 0);
endtask
task t_line;
	u_bus.send(8'h0A, 0);
	apb(0, 8'h00, 0);
	chk("nl", rd[5], 1);
	u_bus.listen(0);
	u_bus.send(8'h41, 0);
	apb(0, 8'h00, 0);
	chk("nl", rd[5], 1);
	u_bus.listen(1);
	u_bus.send(8'h41, 0);
	apb(0, 8'h00, 0);
	chk("nl", rd[5], 0);
	apb(1, 8'h04, 32'hA0);
	u_bus.send(8'h8A, 0);
	chk("end", ends, 1);
	apb(1, 8'h04, 32'h80);
	u_bus.send(8'h8A, 0);
	u_bus.send(8'h30, 1);
	chk("end", ends, 2);
	apb(1, 8'h10, 32'h4102);
	u_bus.send(8'h41, 0);
	apb(0, 8'h00, 0);
	chk("eos", rd[4], 1);
	u_bus.send(8'h42, 0);
	apb(0, 8'h00, 0);
	chk("eos", rd[4], 0);
	u_bus.send(8'h41, 0);
	apb(1, 8'h10, 0);
	apb(0, 8'h00, 0);
	chk("eos", rd[4], 0);
endtask
task t_ifc;
	apb(1, 8'h04, 32'h8C);
	u_bus.pulse(1);
	w(2);
	chk("irq", irq_n, 0);
	apb(0, 8'h00, 0);
	chk("ifc", rd[3], 1);
	apb(0, 8'h00, 0);
	chk("ifc", rd[3], 0);
	apb(1, 8'h10, 32'h01);
	u_bus.pulse(0);
	apb(0, 8'h00, 0);
	chk("atn", rd[2], 1);
	apb(0, 8'h00, 0);
	chk("atn", rd[2], 1);
	apb(1, 8'h0C, 32'h02);
	apb(0, 8'h00, 0);
	chk("atn", rd[2], 0);
	apb(1, 8'h10, 32'h00);
	// ATN event lands on the setup edge of the read
	fork
		u_bus.pulse(0);
		begin
			w(2);
			apb(0, 8'h00, 0);
		end
	join
	chk("atn", rd[2], 0);
	apb(0, 8'h00, 0);
	chk("atn", rd[2], 1);
	apb(1, 8'h04, 32'h0C);
	u_bus.pulse(1);
	w(4);
	chk("irq", irq_n, 1);
	apb(1, 8'h0C, 32'h01);
	apb(0, 8'h00, 0);
	chk("ifc", rd[3], 0);
endtask
initial begin
	repeat (4) @(posedge clk);
	rst_n <= 1'b1;
	repeat (3) @(posedge clk);
	t_poll;
	t_line;
	t_ifc;
	end_of_test;
end
endmodule // gpib_status_group_zero_bench
